// File: logic/pefs_pkg.sv
// Package for the pad extended function selector bank.
// Assumes a 32-bit APB slave on one 40 MHz clock.
`default_nettype none
package pefs_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned SEL_W = 6;
    localparam int unsigned PRI_W = 3;
    localparam int unsigned FIELDS_PER_REG = 4;
    localparam int unsigned FIELD_STRIDE = 8;
    localparam int unsigned NUM_REGS = 4;
    localparam int unsigned NUM_PINS = NUM_REGS * FIELDS_PER_REG;
    localparam logic [ADDR_W-1:0] BASE_ADDR = 32'h4000b1a0;
    localparam logic [ADDR_W-1:0] SEL0_ADDR = 32'h4000b1a0;
    localparam logic [ADDR_W-1:0] SEL1_ADDR = 32'h4000b1a4;
    localparam logic [ADDR_W-1:0] SEL2_ADDR = 32'h4000b1a8;
    localparam logic [ADDR_W-1:0] SEL3_ADDR = 32'h4000b1ac;
    localparam logic [DATA_W-1:0] SEL_RESET = 32'h3f3f3f3f;
    localparam logic [DATA_W-1:0] SEL_MASK = 32'h3f3f3f3f;
    localparam logic [SEL_W-1:0] FIELD_RESET = 6'h3f;
    localparam logic [PRI_W-1:0] PRI_EXTENDED = 3'h1;
    localparam logic [SEL_W-1:0] SEL_NONE = 6'h3f;
endpackage : pefs_pkg
`default_nettype wire

// File: logic/pefs_route.sv
// Per-pin route gate: passes the extended selector only on the extended route.
// Assumes the primary selector comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pefs_route (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pefs_pkg::PRI_W-1:0] primary_function_selector,
    input wire logic [pefs_pkg::SEL_W-1:0] extended_function_selector,
    output logic active,
    output logic [pefs_pkg::SEL_W-1:0] route
);
    logic active_nxt;
    logic [pefs_pkg::SEL_W-1:0] route_nxt;

    // Gate the extended selector by the primary field
    always_comb begin
        active_nxt = (primary_function_selector == pefs_pkg::PRI_EXTENDED); // [RULE_06]
        route_nxt = active_nxt ? extended_function_selector : pefs_pkg::SEL_NONE; // [RULE_03]
    end

    // Register the routed choice
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            route <= pefs_pkg::SEL_NONE;
        end else begin
            active <= active_nxt;
            route <= route_nxt;
        end
    end

    a_route_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (primary_function_selector != pefs_pkg::PRI_EXTENDED) |=> (route == pefs_pkg::SEL_NONE && !active)) // [RULE_03]
        else $error("route passed while primary select not extended");
    a_route_passes: assert property (@(posedge clk) disable iff (!rst_n)
        (primary_function_selector == pefs_pkg::PRI_EXTENDED) |=> (active && route == $past(extended_function_selector))) // [RULE_06]
        else $error("extended route not applied");
endmodule // pefs_route
`default_nettype wire

// File: logic/pefs_top.sv
// Pad extended function selector bank: four APB registers, sixteen 6-bit selectors.
// Assumes an APB master on SYS_CLK and primary selectors from the pin mux on the same clock.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Each register holds four 6-bit read/write selectors at 29:24, 21:16, 13:8, 5:0.
// RULE_02: Lowest pin of a register sits in bits 5:0, highest in 29:24.
// RULE_03: Extended selector drives a pin only while its primary field holds 1.
// RULE_04: Reset loads every selector register with 0x3F3F3F3F.
// RULE_05: Registers for pins 0-3, 4-7, 8-11 decode at 0x4000B1A0, A4, A8.
// RULE_06: Primary value 0x1 hands the pin to its extended selector.
// RULE_07: Register for pins 12-15 decodes at 0x4000B1AC, same layout.
// RULE_08: Unused bit pairs ignore writes and read as zero.
module pefs_top #(
    parameter int unsigned NUM_REGS = pefs_pkg::NUM_REGS
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pefs_pkg::ADDR_W-1:0] PADDR,
    input wire logic [pefs_pkg::DATA_W-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [pefs_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NUM_REGS*pefs_pkg::FIELDS_PER_REG*pefs_pkg::PRI_W-1:0] PRIMARY_SEL,
    output logic [NUM_REGS*pefs_pkg::FIELDS_PER_REG-1:0] ROUTE_ACTIVE,
    output logic [NUM_REGS*pefs_pkg::FIELDS_PER_REG*pefs_pkg::SEL_W-1:0] EXTENDED_ROUTE
);
    localparam int unsigned PINS = NUM_REGS * pefs_pkg::FIELDS_PER_REG;

    // Elaboration check: the decoder serves one to four registers only
    generate
        if (NUM_REGS < 1 || NUM_REGS > pefs_pkg::NUM_REGS) begin : g_bad_regs
            $error("NUM_REGS out of range");
        end
    endgenerate

    // Word index of an address, or -1 when unmapped
    function automatic int reg_index(input logic [pefs_pkg::ADDR_W-1:0] a);
        int idx;
        idx = -1;
        unique case (a)
            pefs_pkg::SEL0_ADDR: idx = 0; // [RULE_05]
            pefs_pkg::SEL1_ADDR: idx = 1; // [RULE_05]
            pefs_pkg::SEL2_ADDR: idx = 2; // [RULE_05]
            pefs_pkg::SEL3_ADDR: idx = 3; // [RULE_07]
            default: idx = -1;
        endcase
        if (idx >= int'(NUM_REGS)) begin
            idx = -1;
        end
        return idx;
    endfunction

    logic [pefs_pkg::DATA_W-1:0] sel_r [NUM_REGS];
    logic [pefs_pkg::DATA_W-1:0] sel_nxt [NUM_REGS];
    logic [pefs_pkg::DATA_W-1:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    int widx;
    logic [pefs_pkg::DATA_W-1:0] strb_mask;

    // Access-phase decode: one wait state, access completes with PREADY
    always_comb begin
        widx = reg_index(PADDR);
        for (int b = 0; b < 4; b++) begin
            strb_mask[b*8 +: 8] = PSTRB[b] ? 8'hff : 8'h00;
        end
        prdata_nxt = '0;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        for (int i = 0; i < int'(NUM_REGS); i++) begin
            sel_nxt[i] = sel_r[i];
        end
        if (PSEL && PENABLE && !pready_r) begin
            pready_nxt = 1'b1;
            pslverr_nxt = (widx < 0);
            if (widx >= 0) begin
                if (PWRITE) begin
                    // Masked merge keeps reserved pairs at zero
                    sel_nxt[widx] = ((sel_r[widx] & ~strb_mask) | (PWDATA & strb_mask))
                                    & pefs_pkg::SEL_MASK; // [RULE_01] [RULE_08]
                end else begin
                    prdata_nxt = sel_r[widx] & pefs_pkg::SEL_MASK; // [RULE_08]
                end
            end
        end
    end

    // Register bank and bus answer
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < int'(NUM_REGS); i++) begin
                sel_r[i] <= pefs_pkg::SEL_RESET; // [RULE_04]
            end
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            for (int i = 0; i < int'(NUM_REGS); i++) begin
                sel_r[i] <= sel_nxt[i];
            end
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;

    // One route gate per pin; field f of register r serves pin 4*r+f
    generate
        for (genvar p = 0; p < PINS; p++) begin : g_pin
            localparam int unsigned R = p / pefs_pkg::FIELDS_PER_REG;
            localparam int unsigned F = p % pefs_pkg::FIELDS_PER_REG;
            pefs_route u_route (
                .clk(SYS_CLK),
                .rst_n(RESETN),
                .primary_function_selector(PRIMARY_SEL[p*pefs_pkg::PRI_W +: pefs_pkg::PRI_W]),
                .extended_function_selector(sel_r[R][F*pefs_pkg::FIELD_STRIDE +: pefs_pkg::SEL_W]), // [RULE_02]
                .active(ROUTE_ACTIVE[p]),
                .route(EXTENDED_ROUTE[p*pefs_pkg::SEL_W +: pefs_pkg::SEL_W])
            );
        end
    endgenerate

    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence

    sequence s_done;
        PREADY && PSEL && PENABLE;
    endsequence

    a_bus_answer: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        s_access |=> s_done)
        else $error("no answer one cycle after access");
    a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        PREADY |-> ((PRDATA & ~pefs_pkg::SEL_MASK) == '0)) // [RULE_08]
        else $error("reserved bits read nonzero");
    a_reset_value: assert property (@(posedge SYS_CLK)
        $rose(RESETN) |-> (sel_r[0] == pefs_pkg::SEL_RESET)) // [RULE_04]
        else $error("selector not at reset value");
    a_write_low: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (s_access and (PWRITE && PADDR == pefs_pkg::SEL0_ADDR && PSTRB[0]))
        |=> (sel_r[0][5:0] == $past(PWDATA[5:0]))) // [RULE_01] [RULE_05]
        else $error("field 0 write lost");
    a_write_top: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (s_access and (PWRITE && PADDR == pefs_pkg::SEL0_ADDR && PSTRB[3]))
        |=> (sel_r[0][29:24] == $past(PWDATA[29:24]))) // [RULE_02]
        else $error("field 3 write lost");
    a_pin3_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (PRIMARY_SEL[11:9] == pefs_pkg::PRI_EXTENDED) |=> (EXTENDED_ROUTE[23:18] == $past(sel_r[0][29:24]))) // [RULE_02]
        else $error("pin 3 not fed from top field");
    a_unmapped_err: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (s_access and (reg_index(PADDR) < 0)) |=> PSLVERR)
        else $error("unmapped access without error");
    a_last_decode: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (s_access and (!PWRITE && PADDR == pefs_pkg::SEL3_ADDR && NUM_REGS == 4))
        |=> (!PSLVERR && PRDATA == sel_r[NUM_REGS-1])) // [RULE_07]
        else $error("pins 12-15 register misdecoded");
    a_route_off: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (PRIMARY_SEL[2:0] != pefs_pkg::PRI_EXTENDED) |=> !ROUTE_ACTIVE[0]) // [RULE_03]
        else $error("pin 0 routed off extended route");
endmodule // pefs_top
`default_nettype wire

// File: verification/pefs_pin_mux.sv
// Model of the primary pin mux that feeds the selector bank.
// Assumes one clock; a value set by the bench reaches the bank one cycle later.
`timescale 1ns/1ps
`default_nettype none
module pefs_pin_mux (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [47:0] want,
    output logic [47:0] prim
);
    // Registered primary selectors; every pin is on route 0 after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prim <= '0;
        end else begin
            prim <= want;
        end
    end
endmodule // pefs_pin_mux
`default_nettype wire

// File: verification/tb_pad_extended_function_select.sv
// Testbench for the pad extended function selector bank.
// Assumes pefs_top with four registers and the pin mux model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_pad_extended_function_select;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [3:0] strb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [47:0] want = '0;
    logic [47:0] prim;
    logic [15:0] act;
    logic [95:0] route;
    logic [31:0] rd;
    logic err;
    logic [31:0] wd [4];
    int num_errors = 0;
    int comparisons = 0;
    // Clock at 40 MHz
    always #12.5 clk = ~clk;
    pefs_pin_mux MUX (.clk(clk), .rst_n(rst_n), .want(want), .prim(prim));
    pefs_top DUT (.SYS_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PRIMARY_SEL(prim), .ROUTE_ACTIVE(act), .EXTENDED_ROUTE(route));
    // Compare register words
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compare pin-side outputs
    task automatic chk_pin(input logic [95:0] got, input logic [95:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer taken at the edge where PREADY is high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        // Sample PREADY at each rising edge; the answer is taken at the edge where it is high
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
    endtask
    // Reset values of every register and idle routes
    task automatic t_reset;
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, 32'h4000b1a0 + 32'(4 * r), '0);
            chk_reg(rd, 32'h3f3f3f3f);
        end
        chk_pin(route, {16{6'h3f}});
        chk_pin(96'(act), '0);
    endtask
    // Write every field with the spare bits set, then read back
    task automatic t_write;
        for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 4; f++) wd[r][8*f +: 8] = {2'h3, 6'(4 * r + f + 16)};
            apb(1'b1, 32'h4000b1a0 + 32'(4 * r), wd[r]);
        end
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, 32'h4000b1a0 + 32'(4 * r), '0);
            chk_reg(rd, wd[r] & 32'h3f3f3f3f);
        end
        // One byte lane only: the other fields of the word must stay as they were
        strb = 4'h2;
        apb(1'b1, 32'h4000b1a4, '0);
        strb = 4'hf;
        wd[1][15:8] = 8'h00;
        apb(1'b0, 32'h4000b1a4, '0);
        chk_reg(rd, wd[1] & 32'h3f3f3f3f);
    endtask
    // Primary value 1 hands a pin to its selector, others park it
    task automatic t_route(input logic [47:0] p);
        logic [95:0] e;
        logic [15:0] ea;
        @(posedge clk);
        want <= p;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            ea[i] = (p[3*i +: 3] == 3'h1);
            e[6*i +: 6] = ea[i] ? wd[i/4][8*(i%4) +: 6] : 6'h3f;
        end
        @(negedge clk);
        chk_pin(route, e);
        chk_pin(96'(act), 96'(ea));
    endtask
    // Unmapped address is refused; mapped access has no error
    task automatic t_bad;
        apb(1'b1, 32'h4000b1b0, 32'h12345678);
        chk_reg(32'(err), 32'h1);
        apb(1'b0, 32'h4000b1b0, '0);
        chk_reg(rd, '0);
        apb(1'b0, 32'h4000b1ac, '0);
        chk_reg(rd, wd[3] & 32'h3f3f3f3f);
        chk_reg(32'(err), '0);
    endtask
    // Counts and verdict
    task automatic end_sim;
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence after five cycles of reset
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_write();
        t_route({16{3'h1}});
        t_route(48'hfac688fac688);
        t_route({16{3'h2}});
        t_bad();
        // Reset again in mid-run: every register returns to its reset word
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        end_sim();
    end
    // Watchdog far beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
endmodule // tb_pad_extended_function_select
`default_nettype wire
